/* pwm_trip_map.vh */
// Register map, field positions, reset values and bus responses of the PWM trip control block.
// Assumes inclusion by the design files of this block; holds definitions only.
`ifndef PWM_TRIP_MAP_VH
`define PWM_TRIP_MAP_VH

// Register indices; byte address on the bus is four times the index.
`define IDX_ENABLE_CTRL     8'h79
`define IDX_GATING_CTRL     8'h7a
`define IDX_TRIP_CTRL       8'h7b
`define IDX_IRQ_STATUS      8'h7c
`define IDX_IRQ_MASK        8'h7d
`define IDX_PORT_OUT        8'h7e
`define IDX_GEN_IN          8'h7f

// Reset values.
`define RST_ENABLE_CTRL     8'h00
`define RST_GATING_CTRL     8'h00
`define RST_TRIP_CTRL       8'h00
`define RST_IRQ_MASK        2'h0
`define RST_PORT_OUT        8'h00

// Enable register fields.
`define BIT_PAIR_ENABLE     7
`define BIT_TRIP_FEATURE    6
`define BIT_MASTER_FOLLOW   5
`define BIT_GEN_LO          1
`define BIT_GEN_HI          4
`define BIT_MULTI_GEN       0

// Gating register fields.
`define BIT_INV_GATE_HI     7
`define BIT_INV_GATE_LO     6
`define BIT_TRUE_GATE_HI    5
`define BIT_TRUE_GATE_LO    4
`define BIT_DEADBAND_HI     3
`define BIT_DEADBAND_LO     0
`define GATE_AND            2'h1
`define GATE_OR             2'h2

// Trip register fields.
`define BIT_SRC_HI          7
`define BIT_SRC_LO          4
`define BIT_TRIP_DRIVE_SEL  3
`define BIT_TRIP_LVL_TRUE   2
`define BIT_TRIP_LVL_INV    1
`define BIT_TRIP_DETECTED   0

// Interrupt status bits.
`define BIT_IRQ_TRIP        0
`define BIT_IRQ_RELEASE     1

// AXI4-Lite responses.
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* pwm_bit_sync.v */
// Two flip-flop synchroniser for a vector of asynchronous inputs.
// Assumes one clock; the first stage is read by the second stage only.
`timescale 1ns/1ps
module pwm_bit_sync #(
	parameter WIDTH = 4
) (
	input  wire             clk_i,
	input  wire             reset_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// Two stages of capture into the clock domain.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule // pwm_bit_sync

/* pwm_pair_deadband.v */
// Dead-band delay for one complementary output pair.
// Assumes the raw level comes from logic on the same clock.
`timescale 1ns/1ps
module pwm_pair_deadband #(
	parameter DW = 4
) (
	input  wire          clk_i,
	input  wire          reset_i,
	input  wire          level_i,
	input  wire [DW-1:0] delay_i,
	output reg           true_o,
	output reg           inv_o
);
	reg          prev_q;
	reg [DW-1:0] cnt_q;

	// On each change both sides go low, then the new side rises after delay_i clocks.
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_q <= 1'b0;
			cnt_q  <= {DW{1'b0}};
			true_o <= 1'b0;
			inv_o  <= 1'b0;
		end else begin
			prev_q <= level_i;
			if (level_i != prev_q) begin
				true_o <= (delay_i == {DW{1'b0}}) ? level_i : 1'b0;
				inv_o  <= (delay_i == {DW{1'b0}}) ? ~level_i : 1'b0;
				cnt_q  <= delay_i;
			end else if (cnt_q > {{(DW-1){1'b0}}, 1'b1}) begin
				true_o <= 1'b0;
				inv_o  <= 1'b0;
				cnt_q  <= cnt_q - {{(DW-1){1'b0}}, 1'b1};
			end else begin
				true_o <= level_i;
				inv_o  <= ~level_i;
				cnt_q  <= {DW{1'b0}};
			end
		end
	end
endmodule // pwm_pair_deadband

/* pwm_trip_ctrl.v */
// Enable, gating, dead-band and power-trip control of a four-pair PWM unit, with AXI4-Lite registers.
// Assumes raw generator levels arrive on the system clock; trip inputs are asynchronous pins.
`timescale 1ns/1ps
`include "pwm_trip_map.vh"

module pwm_trip_ctrl #(
	parameter NPAIR = 4,
	parameter DW    = 4
) (
	input  wire             CLK_SYS_I,
	input  wire             RESET_I,
	input  wire [11:0]      AWADDR_I,
	input  wire             AWVALID_I,
	output reg              AWREADY_O,
	input  wire [31:0]      WDATA_I,
	input  wire [3:0]       WSTRB_I,
	input  wire             WVALID_I,
	output reg              WREADY_O,
	output reg  [1:0]       BRESP_O,
	output reg              BVALID_O,
	input  wire             BREADY_I,
	input  wire [11:0]      ARADDR_I,
	input  wire             ARVALID_I,
	output reg              ARREADY_O,
	output reg  [31:0]      RDATA_O,
	output reg  [1:0]       RRESP_O,
	output reg              RVALID_O,
	input  wire             RREADY_I,
	input  wire [NPAIR-1:0] GEN_LEVEL_I,
	input  wire [3:0]       CAPTURE_INPUT_I,
	output reg  [NPAIR-1:0] PWM_TRUE_O,
	output reg  [NPAIR-1:0] PWM_TRUE_OE_O,
	output reg  [NPAIR-1:0] PWM_INV_O,
	output reg  [NPAIR-1:0] PWM_INV_OE_O,
	output reg              IRQ_O
);
	reg  [7:0]       enable_ctrl_q;
	reg  [7:0]       gating_ctrl_q;
	reg  [7:0]       trip_ctrl_q;
	reg  [7:0]       port_out_q;
	reg  [1:0]       irq_status_q;
	reg  [1:0]       irq_mask_q;
	reg              aw_held_q;
	reg              w_held_q;
	reg  [11:0]      aw_addr_q;
	reg  [31:0]      w_data_q;
	reg  [3:0]       w_strb_q;
	wire [3:0]       trip_sync;
	wire [NPAIR-1:0] db_true;
	wire [NPAIR-1:0] db_inv;
	reg  [NPAIR-1:0] gen_sel;
	reg  [NPAIR-1:0] gate_true;
	reg  [NPAIR-1:0] gate_inv;
	reg  [NPAIR-1:0] gen_on;
	wire             trip_event;
	wire             wr_go;
	wire [9:0]       wr_idx;
	wire [9:0]       rd_idx;
	wire             wr_trip_clear;
	reg  [31:0]      rd_word;
	reg              rd_hit;
	wire             wr_hit;
	wire             wr_low_lane;
	wire             sel_enable;
	wire             sel_gating;
	wire             sel_trip;
	wire             sel_status;
	wire             sel_mask;
	wire             sel_port;
	wire             sel_gen_in;
	wire [1:0]       status_set;
	wire [1:0]       status_clr;

	// Trip pins enter the clock domain through two flip-flops.
	pwm_bit_sync #(
		.WIDTH(4)
	) u_trip_sync (
		.clk_i   (CLK_SYS_I),
		.reset_i (RESET_I),
		.async_i (CAPTURE_INPUT_I),
		.sync_o  (trip_sync)
	);

	// OR of all enabled sources while the feature is on.
	assign trip_event = enable_ctrl_q[`BIT_TRIP_FEATURE] &
		(|(trip_sync & trip_ctrl_q[`BIT_SRC_HI:`BIT_SRC_LO]));

	// Master follow routes generator zero to every pair; enables gate each generator.
	always @* begin
		gen_on = enable_ctrl_q[`BIT_GEN_HI:`BIT_GEN_LO] & {NPAIR{enable_ctrl_q[`BIT_MULTI_GEN]}};
		gen_sel = enable_ctrl_q[`BIT_MASTER_FOLLOW] ? {NPAIR{GEN_LEVEL_I[0]}} : GEN_LEVEL_I;
		gen_sel = gen_sel & gen_on;
	end

	// One dead-band stage per pair.
	genvar g;
	generate
		for (g = 0; g < NPAIR; g = g + 1) begin : g_pair
			pwm_pair_deadband #(
				.DW(DW)
			) u_db (
				.clk_i   (CLK_SYS_I),
				.reset_i (RESET_I),
				.level_i (gen_sel[g]),
				.delay_i (gating_ctrl_q[`BIT_DEADBAND_HI:`BIT_DEADBAND_LO]),
				.true_o  (db_true[g]),
				.inv_o   (db_inv[g])
			);
		end
	endgenerate

	// AND or OR gating of each output with its port register bit.
	always @* begin
		case (gating_ctrl_q[`BIT_TRUE_GATE_HI:`BIT_TRUE_GATE_LO])
			`GATE_AND: gate_true = db_true & port_out_q[NPAIR-1:0];
			`GATE_OR:  gate_true = db_true | port_out_q[NPAIR-1:0];
			default:   gate_true = db_true;
		endcase
		case (gating_ctrl_q[`BIT_INV_GATE_HI:`BIT_INV_GATE_LO])
			`GATE_AND: gate_inv = db_inv & port_out_q[2*NPAIR-1:NPAIR];
			`GATE_OR:  gate_inv = db_inv | port_out_q[2*NPAIR-1:NPAIR];
			default:   gate_inv = db_inv;
		endcase
	end

	// Output stage: trip state overrides, otherwise gated levels.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			PWM_TRUE_O    <= {NPAIR{1'b0}};
			PWM_TRUE_OE_O <= {NPAIR{1'b0}};
			PWM_INV_O     <= {NPAIR{1'b0}};
			PWM_INV_OE_O  <= {NPAIR{1'b0}};
		end else if (trip_ctrl_q[`BIT_TRIP_DETECTED]) begin
			PWM_TRUE_O    <= {NPAIR{~trip_ctrl_q[`BIT_TRIP_LVL_TRUE]}};
			PWM_INV_O     <= {NPAIR{~trip_ctrl_q[`BIT_TRIP_LVL_INV]}};
			PWM_TRUE_OE_O <= gen_on & {NPAIR{trip_ctrl_q[`BIT_TRIP_DRIVE_SEL]}};
			PWM_INV_OE_O  <= gen_on & {NPAIR{trip_ctrl_q[`BIT_TRIP_DRIVE_SEL] &
				enable_ctrl_q[`BIT_PAIR_ENABLE]}};
		end else begin
			PWM_TRUE_O    <= gate_true;
			PWM_INV_O     <= gate_inv;
			PWM_TRUE_OE_O <= gen_on;
			PWM_INV_OE_O  <= gen_on & {NPAIR{enable_ctrl_q[`BIT_PAIR_ENABLE]}};
		end
	end

	// Bus write path: address and data are captured in either order.
	assign wr_go  = aw_held_q & w_held_q & ~BVALID_O;
	assign wr_idx = aw_addr_q[11:2];
	assign rd_idx = ARADDR_I[11:2];

	// Index decode of the held write address; the generator input word is read only but answers OKAY.
	assign sel_enable = (wr_idx == {2'h0, `IDX_ENABLE_CTRL});
	assign sel_gating = (wr_idx == {2'h0, `IDX_GATING_CTRL});
	assign sel_trip   = (wr_idx == {2'h0, `IDX_TRIP_CTRL});
	assign sel_status = (wr_idx == {2'h0, `IDX_IRQ_STATUS});
	assign sel_mask   = (wr_idx == {2'h0, `IDX_IRQ_MASK});
	assign sel_port   = (wr_idx == {2'h0, `IDX_PORT_OUT});
	assign sel_gen_in = (wr_idx == {2'h0, `IDX_GEN_IN});
	assign wr_hit     = sel_enable | sel_gating | sel_trip | sel_status |
		sel_mask | sel_port | sel_gen_in;

	// Every register sits in the low byte lane, so only that strobe commits data.
	assign wr_low_lane   = wr_go & w_strb_q[0];
	assign wr_trip_clear = wr_low_lane & sel_trip & ~w_data_q[`BIT_TRIP_DETECTED];

	// Event sources of the sticky status bits and their write-one clears.
	assign status_set = {wr_trip_clear & ~trip_event & trip_ctrl_q[`BIT_TRIP_DETECTED],
		trip_event & ~trip_ctrl_q[`BIT_TRIP_DETECTED]};
	assign status_clr = {2{wr_low_lane & sel_status}} & w_data_q[1:0];

	// Handshake registers of the write channels.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= `RESP_OKAY;
		end else begin
			AWREADY_O <= ~aw_held_q & ~AWREADY_O & AWVALID_I;
			WREADY_O  <= ~w_held_q & ~WREADY_O & WVALID_I;
			if (AWVALID_I & AWREADY_O) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= AWADDR_I;
			end
			if (WVALID_I & WREADY_O) begin
				w_held_q <= 1'b1;
				w_data_q <= WDATA_I;
				w_strb_q <= WSTRB_I;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				BVALID_O  <= 1'b1;
				BRESP_O   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (BVALID_O & BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end

	// Configuration registers, written through the low byte lane of a committed write.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			enable_ctrl_q <= `RST_ENABLE_CTRL;
			gating_ctrl_q <= `RST_GATING_CTRL;
			port_out_q    <= `RST_PORT_OUT;
			irq_mask_q    <= `RST_IRQ_MASK;
		end else begin
			if (wr_low_lane & sel_enable)
				enable_ctrl_q <= w_data_q[7:0];
			if (wr_low_lane & sel_gating)
				gating_ctrl_q <= w_data_q[7:0];
			if (wr_low_lane & sel_mask)
				irq_mask_q <= w_data_q[1:0];
			if (wr_low_lane & sel_port)
				port_out_q <= w_data_q[7:0];
		end
	end

	// Trip register; the detect flag is set by hardware and only cleared by software.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			trip_ctrl_q <= `RST_TRIP_CTRL;
		end else begin
			if (wr_low_lane & sel_trip)
				trip_ctrl_q[7:1] <= w_data_q[7:1];
			// Set wins over a clear in the same cycle, so a trip present then is never lost.
			if (trip_event)
				trip_ctrl_q[`BIT_TRIP_DETECTED] <= 1'b1;
			else if (wr_trip_clear)
				trip_ctrl_q[`BIT_TRIP_DETECTED] <= 1'b0;
		end
	end

	// Sticky event bits; a set in the same cycle as a write-one clear wins.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I)
			irq_status_q <= 2'h0;
		else
			irq_status_q <= status_set | (irq_status_q & ~status_clr);
	end

	// Interrupt level from unmasked status.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_status_q & irq_mask_q);
	end

	// Read decode.
	always @* begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case (rd_idx)
			{2'h0, `IDX_ENABLE_CTRL}: rd_word[7:0] = enable_ctrl_q;
			{2'h0, `IDX_GATING_CTRL}: rd_word[7:0] = gating_ctrl_q;
			{2'h0, `IDX_TRIP_CTRL}:   rd_word[7:0] = trip_ctrl_q;
			{2'h0, `IDX_IRQ_STATUS}:  rd_word[1:0] = irq_status_q;
			{2'h0, `IDX_IRQ_MASK}:    rd_word[1:0] = irq_mask_q;
			{2'h0, `IDX_PORT_OUT}:    rd_word[7:0] = port_out_q;
			{2'h0, `IDX_GEN_IN}:      rd_word[7:0] = {trip_sync, GEN_LEVEL_I[3:0]};
			default:                  rd_hit = 1'b0;
		endcase
	end

	// Read channel: address taken, data one cycle later.
	always @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h00000000;
			RRESP_O   <= `RESP_OKAY;
		end else begin
			ARREADY_O <= ~ARREADY_O & ~RVALID_O & ARVALID_I;
			if (ARVALID_I & ARREADY_O) begin
				RVALID_O <= 1'b1;
				RDATA_O  <= rd_word;
				RRESP_O  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (RVALID_O & RREADY_I) begin
				RVALID_O <= 1'b0;
			end
		end
	end
endmodule // pwm_trip_ctrl

/* pwm_trip_ctrl_assertions.sv */
// Checker of bus handshakes and pin enables of the PWM trip control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pwm_trip_ctrl_assertions #(
	parameter NPAIR = 4
) (
	input wire             CLK_SYS_I,
	input wire             RESET_I,
	input wire             AWVALID_I,
	input wire             AWREADY_O,
	input wire             BVALID_O,
	input wire             BREADY_I,
	input wire             ARVALID_I,
	input wire             ARREADY_O,
	input wire             RVALID_O,
	input wire             RREADY_I,
	input wire             IRQ_O,
	input wire [1:0]       BRESP_O,
	input wire [31:0]      RDATA_O,
	input wire [NPAIR-1:0] PWM_TRUE_OE_O,
	input wire [NPAIR-1:0] PWM_INV_OE_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	// The write address ready strobe is a single pulse answering a request.
	chk_aw_pulse: assert property (AWREADY_O |=> !AWREADY_O) else $error("aw ready too long");
	chk_aw_cause: assert property (AWREADY_O |-> $past(AWVALID_I)) else $error("aw ready unasked");
	// Responses come in time and stand until taken.
	chk_b_latency: assert property (AWVALID_I && AWREADY_O |-> ##[1:4] BVALID_O) else $error("b late");
	chk_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O)) else $error("b dropped");
	chk_r_latency: assert property (ARVALID_I && ARREADY_O |=> RVALID_O) else $error("r late");
	chk_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O)) else $error("r dropped");
	chk_r_upper: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0) else $error("r upper bits set");
	// Pins stay undriven out of reset, and an inverted pin never drives alone.
	chk_reset_idle: assert property ($fell(RESET_I) |-> (PWM_TRUE_OE_O | PWM_INV_OE_O) == 0) else $error("pins driven");
	chk_inv_pair: assert property ((PWM_INV_OE_O & ~PWM_TRUE_OE_O) == 0) else $error("inv pin alone");
	cov_slverr: cover property (BVALID_O && BREADY_I && BRESP_O == 2'h2);
	cov_irq: cover property ($rose(IRQ_O));
	cov_float: cover property (PWM_TRUE_OE_O == 0 && IRQ_O);
endmodule // pwm_trip_ctrl_assertions
bind pwm_trip_ctrl pwm_trip_ctrl_assertions #(.NPAIR(NPAIR)) chk_inst (.CLK_SYS_I, .RESET_I, .AWVALID_I,
	.AWREADY_O, .BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RVALID_O, .RREADY_I, .IRQ_O, .BRESP_O,
	.RDATA_O, .PWM_TRUE_OE_O, .PWM_INV_OE_O);

/* pwm_stage_model.sv */
// Model of the power stage: trip sensors and pull-down gate driver inputs.
// Assumes the bench commands the fault levels.
`timescale 1ns/1ps
module pwm_stage_model (
	input  wire logic [3:0] fault_i,
	input  wire logic [3:0] lvl_i,
	input  wire logic [3:0] oe_i,
	output wire logic [3:0] trip_o,
	output wire logic [3:0] pin_o
);
	// Sensors switch off the clock grid, so glitches arrive unsynchronised.
	assign #3 trip_o = fault_i;
	// A floated gate input is pulled low by its driver.
	assign pin_o = oe_i & lvl_i;
endmodule // pwm_stage_model

/* pwm_trip_ctrl_tb_top.sv */
// Self-checking bench of the PWM trip control block against a register model.
// Assumes the stage model supplies the trip pins and resolves the true pins.
`timescale 1ns/1ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module pwm_trip_ctrl_tb_top;
	logic        CLK_SYS_I = 0, RESET_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
	logic [11:0] AWADDR_I = 0, ARADDR_I = 0;
	logic [31:0] WDATA_I = 0;
	logic [3:0]  WSTRB_I = 4'hf, GEN_LEVEL_I = 0, flt = 0;
	wire         AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
	wire  [1:0]  BRESP_O, RRESP_O;
	wire  [31:0] RDATA_O;
	wire  [3:0]  CAPTURE_INPUT_I, PWM_TRUE_O, PWM_TRUE_OE_O, PWM_INV_O, PWM_INV_OE_O, pin;
	int          num_errors = 0, checks = 0, regs [int];
	pwm_trip_ctrl pwm_trip_ctrl_inst (.CLK_SYS_I, .RESET_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I,
		.WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O,
		.RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .GEN_LEVEL_I, .CAPTURE_INPUT_I, .PWM_TRUE_O,
		.PWM_TRUE_OE_O, .PWM_INV_O, .PWM_INV_OE_O, .IRQ_O);
	pwm_stage_model pwm_stage_model_inst (.fault_i(flt), .lvl_i(PWM_TRUE_O), .oe_i(PWM_TRUE_OE_O),
		.trip_o(CAPTURE_INPUT_I), .pin_o(pin));
	// System clock of 100 MHz.
	always #5 CLK_SYS_I = ~CLK_SYS_I;
	// Prints the counts and the verdict, then stops.
	task conclude;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task tk(input int m);
		repeat (m) @(posedge CLK_SYS_I);
	endtask
	// A used-up wait bound counts as a mismatch and ends the run.
	task to(input int n);
		if (n >= 60) begin
			num_errors++;
			$display("[ERR] wait exp done got timeout");
			conclude;
		end
	endtask
	// Write with address and data offered together.
	task wr(input [9:0] i, input [7:0] d, input [1:0] e = 2'h0);
		int n;
		bit a, w;
		@(posedge CLK_SYS_I);
		AWADDR_I <= {i, 2'h0};
		WDATA_I <= {24'h0, d};
		AWVALID_I <= 1;
		WVALID_I <= 1;
		a = 1;
		w = 1;
		n = 0;
		while ((a || w) && n < 60) begin
			tk(1);
			n++;
			if (AWREADY_O === 1'b1) begin a = 0; AWVALID_I <= 0; end
			if (WREADY_O === 1'b1) begin w = 0; WVALID_I <= 0; end
		end
		while (BVALID_O !== 1'b1 && n < 60) begin tk(1); n++; end
		to(n);
		// Taking the response one cycle late exercises its hold.
		BREADY_I <= 1;
		tk(1);
		BREADY_I <= 0;
		`CK("bresp", e, BRESP_O)
		if (e == 0) regs[i] = d;
	endtask
	task rd(input [9:0] i, input [7:0] d, input [1:0] e = 2'h0);
		int n;
		@(posedge CLK_SYS_I);
		ARADDR_I <= {i, 2'h0};
		ARVALID_I <= 1;
		n = 0;
		do begin tk(1); n++; end while (ARREADY_O !== 1'b1 && n < 60);
		ARVALID_I <= 0;
		while (RVALID_O !== 1'b1 && n < 60) begin tk(1); n++; end
		to(n);
		// Taking the data one cycle late exercises its hold.
		RREADY_I <= 1;
		tk(1);
		RREADY_I <= 0;
		`CK("rresp", e, RRESP_O)
		`CK("rdata", {24'h0, d}, RDATA_O)
	endtask
	task wi;
		int n;
		n = 0;
		do begin tk(1); n++; end while (IRQ_O !== 1'b1 && n < 60);
		to(n);
	endtask
	function automatic logic [3:0] gt(input logic [3:0] v, p, input logic [1:0] m);
		return m == 2'h1 ? v & p : m == 2'h2 ? v | p : v;
	endfunction
	// Main sequence: registers, enables, gating, dead-band, trip.
	initial begin
		int k, s, v;
		void'($urandom(32'h4b0e));
		tk(3);
		RESET_I <= 0;
		for (k = 'h79; k < 'h7c; k++) rd(k[9:0], 8'h0);
		rd(10'h010, 8'h0, 2'h2);
		wr(10'h010, 8'h5a, 2'h2);
		for (k = 'h79; k < 'h7b; k++) begin
			v = $urandom;
			wr(k[9:0], v[7:0]);
			rd(k[9:0], regs[k]);
		end
		wr(10'h07a, 8'h0);
		wr(10'h079, 8'h1b);
		tk(4);
		`CK("inv_oe", 4'h0, PWM_INV_OE_O)
		`CK("true_oe", 4'hd, PWM_TRUE_OE_O)
		wr(10'h079, 8'h9f);
		tk(4);
		`CK("pair_oe", 4'hf, PWM_INV_OE_O)
		GEN_LEVEL_I <= 4'h1;
		wr(10'h079, 8'hbf);
		tk(4);
		`CK("follow", 4'hf, PWM_TRUE_O)
		wr(10'h079, 8'h9f);
		for (k = 0; k < 16; k++) begin
			v = $urandom;
			GEN_LEVEL_I <= v[11:8];
			wr(10'h07e, v[7:0]);
			wr(10'h07a, {k[3:0], 4'h0});
			tk(4);
			`CK("true", gt(v[11:8], v[3:0], k[1:0]), PWM_TRUE_O)
			`CK("inv", gt(~v[11:8], v[7:4], k[3:2]), PWM_INV_O)
		end
		s = $urandom_range(15, 1);
		GEN_LEVEL_I <= 4'hf;
		wr(10'h07a, s[7:0]);
		tk(20);
		GEN_LEVEL_I <= 4'h0;
		k = 0;
		v = 0;
		do begin tk(1); v++; if (PWM_TRUE_O[0] === 1'b0 && PWM_INV_O[0] === 1'b0) k++; end
		while (PWM_INV_O[0] !== 1'b1 && v < 60);
		to(v);
		`CK("gap", s, k)
		wr(10'h07a, 8'h0);
		GEN_LEVEL_I <= 4'h5;
		wr(10'h07d, 8'h1);
		wr(10'h079, 8'hdf);
		s = $urandom_range(3, 0);
		v = (16 << s) | 8 | ($urandom & 6);
		wr(10'h07b, v[7:0]);
		flt <= 4'h1 << ((s + 1) % 4);
		tk(10);
		flt <= 4'h0;
		`CK("irq", 1'b0, IRQ_O)
		flt <= 4'h1 << s;
		wi();
		tk(3);
		flt <= 4'h0;
		tk(10);
		`CK("trip_t", {4{~v[2]}}, PWM_TRUE_O)
		`CK("trip_i", {4{~v[1]}}, PWM_INV_O)
		rd(10'h07b, v[7:0] | 8'h1);
		wr(10'h07c, 8'h1);
		tk(3);
		`CK("irq", 1'b0, IRQ_O)
		wr(10'h07b, v[7:0]);
		tk(8);
		`CK("release", 4'h5, PWM_TRUE_O)
		rd(10'h07c, 8'h2);
		wr(10'h07b, 8'hf0);
		flt <= 4'h1 << $urandom_range(3, 0);
		wi();
		tk(3);
		`CK("float", 4'h0, pin)
		`CK("float_oe", 4'h0, PWM_INV_OE_O)
		rd(10'h07b, 8'hf1);
		flt <= 4'h0;
		RESET_I <= 1;
		tk(3);
		RESET_I <= 0;
		`CK("rst_oe", 4'h0, PWM_TRUE_OE_O)
		rd(10'h07b, 8'h0);
		conclude;
	end
endmodule // pwm_trip_ctrl_tb_top
